//--- olsc_pkg.sv
package olsc_pkg;

  // ****************************************
  // register map (word index)
  // ****************************************
  localparam logic [3:0]  OLSC_ADDR_ENABLE_CFG   = 4'h0;
  localparam logic [3:0]  OLSC_ADDR_STOP_CFG     = 4'h1;
  localparam logic [3:0]  OLSC_ADDR_PLUG_TORQUE  = 4'h2;
  localparam logic [3:0]  OLSC_ADDR_ROT_DIR_CFG  = 4'h3;
  localparam logic [3:0]  OLSC_ADDR_STATUS       = 4'h4;
  localparam logic [3:0]  OLSC_ADDR_ACTIVE_CFG   = 4'h5;
  localparam logic [3:0]  OLSC_ADDR_RATED_CAP    = 4'h6;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          OLSC_FWD_DIS_BIT       = 4;
  localparam int          OLSC_REV_DIS_BIT       = 8;
  localparam int          OLSC_ROT_REV_BIT       = 0;
  localparam logic [3:0]  OLSC_STOP_CODE_MAX     = 4'h5;
  localparam logic [15:0] OLSC_CFG_RESET         = 16'h0000;
  localparam logic [15:0] OLSC_TORQUE_RESET      = 16'h012C;
  localparam logic [15:0] OLSC_TORQUE_MAX        = 16'h012C;
  localparam logic [15:0] OLSC_RATED_CAP_RESET   = 16'h012C;

  // ****************************************
  // stop methods and phases
  // ****************************************
  typedef enum logic [3:0] {
    OLSC_STOP_DYN      = 4'h0,
    OLSC_STOP_COAST    = 4'h1,
    OLSC_STOP_PLUG_DYN = 4'h2,
    OLSC_STOP_PLUG_CO  = 4'h3,
    OLSC_STOP_PLUG_ZDB = 4'h4,
    OLSC_STOP_PLUG_ZCO = 4'h5
  } olsc_stop_t;

  typedef enum logic [1:0] {
    OLSC_RUN      = 2'b00,
    OLSC_BRAKING  = 2'b01,
    OLSC_HOLD     = 2'b11
  } olsc_state_t;

  // drive commands leaving the block
  typedef struct packed {
    logic        fwd_permit;
    logic        rev_permit;
    logic        dynamic_brake;
    logic        coast;
    logic        plug_brake;
    logic        zero_clamp;
    logic [15:0] torque_limit;
  } olsc_drive_t;

  // bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } olsc_bus_t;

endpackage : olsc_pkg

//--- olsc_top.sv
// Functional notes
// - forward limit high blocks forward rotation
// - reverse limit high blocks reverse rotation
// - opposite direction stays commandable during overtravel
// - keep position error until controller clears
// - forward disable digit ignores forward limit
// - reverse disable digit ignores reverse limit
// - same behaviour in every control mode
// - config digits apply after power cycle
// - code 0: dynamic brake, then coast
// - code 1: coast stop, then coast
// - codes 2-5 plug brake; coast or clamp
// - servo off: dynamic brake 2,4; coast 3,5
// - zero clamp holds position reference zero
// - plug torque limited by setting, immediate
// - plug torque also capped at rated
// - reverse rotation mode swaps guarded direction
`timescale 1ns/1ps
module olsc_top
  import olsc_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  // power-on load strobe: latches config into active set
  input  wire logic                 power_up_load_i,
  // limit switches
  input  wire logic                 forward_limit_input_i,
  input  wire logic                 reverse_limit_input_i,
  // host motion controller
  input  wire logic                 servo_on_i,
  input  wire logic                 motor_stopped_i,
  input  wire logic                 cmd_fwd_i,
  input  wire logic                 cmd_rev_i,
  input  wire logic                 position_error_clear_i,
  input  wire logic                 error_pulse_i,
  input  wire logic                 error_dir_i,
  // register port
  input  wire olsc_pkg::olsc_bus_t  bus_i,
  output logic [15:0]               rdata_o,
  // drive outputs
  output olsc_pkg::olsc_drive_t     drive_o,
  output logic [15:0]               position_error_o,
  output logic                      fwd_overtravel_o,
  output logic                      rev_overtravel_o
);
  import olsc_pkg::*;

  // ****************************************
  // synchronisers
  // ****************************************
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] next_sync_a;
  logic [1:0] next_sync_b;

  always_comb begin
    next_sync_a = {reverse_limit_input_i, forward_limit_input_i};
    next_sync_b = sync_a;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_a <= 2'b00;
      sync_b <= 2'b00;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] enable_cfg;
  logic [15:0] stop_cfg;
  logic [15:0] torque_cfg;
  logic [15:0] rot_cfg;
  logic [15:0] rated_cap;
  logic [15:0] act_enable;
  logic [15:0] act_stop;
  logic [15:0] act_rot;
  logic [15:0] next_enable_cfg;
  logic [15:0] next_stop_cfg;
  logic [15:0] next_torque_cfg;
  logic [15:0] next_rot_cfg;
  logic [15:0] next_rated_cap;
  logic [15:0] next_act_enable;
  logic [15:0] next_act_stop;
  logic [15:0] next_act_rot;

  function automatic logic wr_hit(input olsc_bus_t b, input logic [3:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction : wr_hit

  always_comb begin
    next_enable_cfg = enable_cfg;
    next_stop_cfg   = stop_cfg;
    next_torque_cfg = torque_cfg;
    next_rot_cfg    = rot_cfg;
    next_rated_cap  = rated_cap;
    next_act_enable = act_enable;
    next_act_stop   = act_stop;
    next_act_rot    = act_rot;
    if (wr_hit(bus_i, OLSC_ADDR_ENABLE_CFG)) begin
      next_enable_cfg = bus_i.wdata;
    end
    if (wr_hit(bus_i, OLSC_ADDR_STOP_CFG)) begin
      next_stop_cfg = bus_i.wdata;
    end
    // torque setting is live at once and saturates at the top of its range
    if (wr_hit(bus_i, OLSC_ADDR_PLUG_TORQUE)) begin
      next_torque_cfg = (bus_i.wdata > OLSC_TORQUE_MAX) ? OLSC_TORQUE_MAX
                                                         : bus_i.wdata;
    end
    if (wr_hit(bus_i, OLSC_ADDR_ROT_DIR_CFG)) begin
      next_rot_cfg = bus_i.wdata;
    end
    if (wr_hit(bus_i, OLSC_ADDR_RATED_CAP)) begin
      next_rated_cap = bus_i.wdata;
    end
    // written digits sit idle until the next power-up load
    if (power_up_load_i) begin
      next_act_enable = enable_cfg;
      next_act_stop   = stop_cfg;
      next_act_rot    = rot_cfg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      enable_cfg <= OLSC_CFG_RESET;
      stop_cfg   <= OLSC_CFG_RESET;
      torque_cfg <= OLSC_TORQUE_RESET;
      rot_cfg    <= OLSC_CFG_RESET;
      rated_cap  <= OLSC_RATED_CAP_RESET;
      act_enable <= OLSC_CFG_RESET;
      act_stop   <= OLSC_CFG_RESET;
      act_rot    <= OLSC_CFG_RESET;
    end else begin
      enable_cfg <= next_enable_cfg;
      stop_cfg   <= next_stop_cfg;
      torque_cfg <= next_torque_cfg;
      rot_cfg    <= next_rot_cfg;
      rated_cap  <= next_rated_cap;
      act_enable <= next_act_enable;
      act_stop   <= next_act_stop;
      act_rot    <= next_act_rot;
    end
  end

  // ****************************************
  // overtravel decode
  // ****************************************
  logic       fwd_ot;
  logic       rev_ot;
  logic       any_ot;
  olsc_stop_t method;

  // no mode input: detection is independent of speed/position/torque mode
  always_comb begin
    // reverse rotation mode swaps which physical input guards forward
    fwd_ot = (act_rot[OLSC_ROT_REV_BIT] ? sync_b[1] : sync_b[0])
             && !act_enable[OLSC_FWD_DIS_BIT];
    rev_ot = (act_rot[OLSC_ROT_REV_BIT] ? sync_b[0] : sync_b[1])
             && !act_enable[OLSC_REV_DIS_BIT];
    any_ot = (fwd_ot && cmd_fwd_i) || (rev_ot && cmd_rev_i);
    // an unknown code behaves as the safest plain stop
    method = (act_stop[3:0] > OLSC_STOP_CODE_MAX) ? OLSC_STOP_DYN
                                                  : olsc_stop_t'(act_stop[3:0]);
  end

  // ****************************************
  // stop sequencer
  // ****************************************
  olsc_state_t state;
  olsc_state_t next_state;
  olsc_drive_t drive;
  olsc_drive_t next_drive;
  logic        plug;
  logic        clamp;

  always_comb begin
    plug  = (method != OLSC_STOP_DYN) && (method != OLSC_STOP_COAST);
    clamp = (method == OLSC_STOP_PLUG_ZDB) || (method == OLSC_STOP_PLUG_ZCO);
    next_state = state;
    unique case (state)
      OLSC_RUN: begin
        if (any_ot) begin
          next_state = OLSC_BRAKING;
        end
      end
      OLSC_BRAKING: begin
        if (motor_stopped_i) begin
          next_state = OLSC_HOLD;
        end
      end
      OLSC_HOLD: begin
        // leave once the axis is commanded back off the limit
        if (!any_ot) begin
          next_state = OLSC_RUN;
        end
      end
      default: next_state = OLSC_RUN;
    endcase
    next_drive = '0;
    next_drive.fwd_permit = !fwd_ot;
    next_drive.rev_permit = !rev_ot;
    next_drive.torque_limit = (torque_cfg < rated_cap) ? torque_cfg
                                                       : rated_cap;
    if (!servo_on_i) begin
      // servo off: dynamic brake for even codes, coast for odd ones
      next_drive.dynamic_brake = !method[0];
      next_drive.coast         = method[0];
    end else if (next_state == OLSC_BRAKING) begin
      next_drive.dynamic_brake = (method == OLSC_STOP_DYN);
      next_drive.coast         = (method == OLSC_STOP_COAST);
      next_drive.plug_brake    = plug;
    end else if (next_state == OLSC_HOLD) begin
      next_drive.coast      = !clamp;
      next_drive.zero_clamp = clamp;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= OLSC_RUN;
      drive <= '0;
    end else begin
      state <= next_state;
      drive <= next_drive;
    end
  end

  // ****************************************
  // position error counter
  // ****************************************
  logic [15:0] pos_err;
  logic [15:0] next_pos_err;

  // counter is never zeroed by an overtravel; only the clear input and reset do it
  always_comb begin
    next_pos_err = pos_err;
    if (position_error_clear_i) begin
      next_pos_err = '0;
    end else if (error_pulse_i) begin
      next_pos_err = error_dir_i ? pos_err - 16'h0001 : pos_err + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pos_err <= '0;
    end else begin
      pos_err <= next_pos_err;
    end
  end

  // ****************************************
  // status and read data
  // ****************************************
  logic        fwd_flag;
  logic        rev_flag;
  logic [15:0] rdata;
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OLSC_ADDR_ENABLE_CFG:  next_rdata = enable_cfg;
        OLSC_ADDR_STOP_CFG:    next_rdata = stop_cfg;
        OLSC_ADDR_PLUG_TORQUE: next_rdata = torque_cfg;
        OLSC_ADDR_ROT_DIR_CFG: next_rdata = rot_cfg;
        OLSC_ADDR_STATUS:      next_rdata = {12'h000, state, rev_flag, fwd_flag};
        OLSC_ADDR_ACTIVE_CFG:  next_rdata = {act_enable[15:4], act_stop[3:0]};
        OLSC_ADDR_RATED_CAP:   next_rdata = rated_cap;
        default:               next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fwd_flag <= 1'b0;
      rev_flag <= 1'b0;
      rdata    <= '0;
    end else begin
      fwd_flag <= fwd_ot;
      rev_flag <= rev_ot;
      rdata    <= next_rdata;
    end
  end

  assign rdata_o          = rdata;
  assign drive_o          = drive;
  assign position_error_o = pos_err;
  assign fwd_overtravel_o = fwd_flag;
  assign rev_overtravel_o = rev_flag;

endmodule : olsc_top

//--- olsc_asserts.sv
`timescale 1ns/1ps
module olsc_asserts
  import olsc_pkg::*;
(
  // clock and reset
  input wire logic                  ref_clk_i,
  input wire logic                  rst_i,
  // watched inputs
  input wire logic                  power_up_load_i,
  input wire logic                  forward_limit_input_i,
  input wire logic                  reverse_limit_input_i,
  input wire logic                  servo_on_i,
  input wire logic                  position_error_clear_i,
  input wire logic                  error_pulse_i,
  input wire olsc_pkg::olsc_bus_t   bus_i,
  // watched outputs
  input wire logic [15:0]           rdata_o,
  input wire olsc_pkg::olsc_drive_t drive_o,
  input wire logic [15:0]           position_error_o,
  input wire logic                  fwd_overtravel_o,
  input wire logic                  rev_overtravel_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // rotation mode as the block holds it: written, then taken at power-up
  logic rot_pend;
  logic rot_act;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rot_pend <= 1'b0;
      rot_act  <= 1'b0;
    end else begin
      if (bus_i.wr && (bus_i.addr == OLSC_ADDR_ROT_DIR_CFG)) begin
        rot_pend <= bus_i.wdata[OLSC_ROT_REV_BIT];
      end
      if (power_up_load_i) begin
        rot_act <= rot_pend;
      end
    end
  end
  // *****
  // limit and counter steps
  // *****
  sequence fwd_hit;
    $rose(forward_limit_input_i) ##3 fwd_overtravel_o;
  endsequence
  sequence err_idle;
    !position_error_clear_i && !error_pulse_i;
  endsequence
  // flag lags the pin by the two sync stages plus its own register
  fwd_flag_a: assert property (fwd_overtravel_o |->
    ($past(rot_act) ? $past(reverse_limit_input_i, 3) : $past(forward_limit_input_i, 3)))
    else $error("forward flag without its guarding limit");
  fwd_block_a: assert property (fwd_overtravel_o |-> !drive_o.fwd_permit)
    else $error("forward permit during forward overtravel");
  rev_block_a: assert property (rev_overtravel_o |-> !drive_o.rev_permit)
    else $error("reverse permit during reverse overtravel");
  back_off_a: assert property (fwd_overtravel_o && !rev_overtravel_o && servo_on_i
    && $past(servo_on_i) |-> drive_o.rev_permit) else $error("reverse blocked on forward limit");
  torque_cap_a: assert property (drive_o.torque_limit <= 16'h012C)
    else $error("torque limit above ceiling");
  err_clear_a: assert property (position_error_clear_i |=> position_error_o == 16'h0000)
    else $error("error count not cleared");
  err_keep_a: assert property (err_idle |=> $stable(position_error_o))
    else $error("error count moved without pulse");
  read_idle_a: assert property (!bus_i.rd |=> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  fwd_hit_c: cover property (fwd_hit);
endmodule : olsc_asserts

bind olsc_top olsc_asserts u_chk (.ref_clk_i, .rst_i, .power_up_load_i, .forward_limit_input_i,
  .reverse_limit_input_i, .servo_on_i,
  .position_error_clear_i, .error_pulse_i, .bus_i, .rdata_o, .drive_o, .position_error_o,
  .fwd_overtravel_o, .rev_overtravel_o);

//--- olsc_partner.sv
`timescale 1ns/1ps
module olsc_partner (
  // clock
  input  wire logic clk_i,
  // limit switches
  output logic      fwd_lim_o,
  output logic      rev_lim_o,
  // host controller
  output logic      servo_on_o,
  output logic      cmd_fwd_o,
  output logic      cmd_rev_o,
  output logic      stopped_o,
  output logic      clr_o,
  output logic      pulse_o,
  output logic      dir_o
);
  initial begin
    {fwd_lim_o, rev_lim_o, cmd_fwd_o, cmd_rev_o, stopped_o, clr_o, pulse_o, dir_o} = '0;
    servo_on_o = 1'b1;
  end
  task automatic set_lim(input logic f, input logic r);
    @(posedge clk_i);
    fwd_lim_o <= f;
    rev_lim_o <= r;
  endtask : set_lim
  // motion is steered by commands; servo is dropped only to probe the off stop
  task automatic set_host(input logic s, input logic f, input logic r, input logic m);
    @(posedge clk_i);
    {servo_on_o, cmd_fwd_o, cmd_rev_o, stopped_o} <= {s, f, r, m};
  endtask : set_host
  task automatic count(input logic d);
    @(posedge clk_i);
    pulse_o <= 1'b1;
    dir_o   <= d;
    @(posedge clk_i);
    pulse_o <= 1'b0;
  endtask : count
  task automatic clear;
    @(posedge clk_i);
    clr_o <= 1'b1;
    @(posedge clk_i);
    clr_o <= 1'b0;
  endtask : clear
endmodule : olsc_partner

//--- tb_overtravel_limit_stop_control.sv
`timescale 1ns/1ps
module tb_overtravel_limit_stop_control;
  import olsc_pkg::*;
  logic        ref_clk_i, rst_i, load, d, ff, rf;
  logic        fl, rl, son, cf, cr, stp, clr, ep, ed, fot, rot;
  logic [15:0] rdata, perr, rv, en, t, exp_err;
  logic [15:0] rst_v [8] = '{16'h0000, 16'h0000, 16'h012C, 16'h0000,
                             16'h0000, 16'h0000, 16'h012C, 16'h0000};
  logic [3:0]  c, q;
  int          n_mismatch = 0, total_checks = 0;
  olsc_bus_t   bus;
  olsc_drive_t drv;
  olsc_partner u_ptn (.clk_i(ref_clk_i), .fwd_lim_o(fl), .rev_lim_o(rl), .servo_on_o(son),
    .cmd_fwd_o(cf), .cmd_rev_o(cr), .stopped_o(stp), .clr_o(clr), .pulse_o(ep), .dir_o(ed));
  olsc_top dut (.ref_clk_i, .rst_i, .power_up_load_i(load), .forward_limit_input_i(fl),
    .reverse_limit_input_i(rl), .servo_on_i(son), .motor_stopped_i(stp), .cmd_fwd_i(cf),
    .cmd_rev_i(cr), .position_error_clear_i(clr), .error_pulse_i(ep), .error_dir_i(ed),
    .bus_i(bus), .rdata_o(rdata), .drive_o(drv), .position_error_o(perr),
    .fwd_overtravel_o(fot), .rev_overtravel_o(rot));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // *****
  // helpers
  // *****
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  // stands in for a full power cycle of the drive
  task automatic cycle_power;
    @(posedge ref_clk_i);
    load <= 1'b1;
    @(posedge ref_clk_i);
    load <= 1'b0;
    tick(1);
  endtask : cycle_power
  function automatic logic [15:0] modes();
    return 16'({drv.dynamic_brake, drv.coast, drv.plug_brake, drv.zero_clamp});
  endfunction : modes
  // phase 0 braking, 1 after standstill, 2 servo off
  function automatic logic [15:0] exp_mode(input int ph, input logic [3:0] k);
    case (ph)
      0: return 16'({k == 4'h0, k == 4'h1, k > 4'h1, 1'b0});
      1: return 16'({1'b0, k < 4'h4, 1'b0, k > 4'h3});
      default: return 16'({~k[0], k[0], 2'b00});
    endcase
  endfunction : exp_mode
  task automatic print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_mismatch++;
    print_verdict;
  end
  // *****
  // main sequence
  // *****
  initial begin
    void'($urandom(32'hE987AABD));
    rst_i <= 1'b1;
    load  <= 1'b0;
    bus   <= '0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      reg_rd(4'(i), rv);
      chk("reset value", rv, rst_v[i]);
    end
    reg_wr(OLSC_ADDR_PLUG_TORQUE, 16'h01F4);
    reg_rd(OLSC_ADDR_PLUG_TORQUE, rv);
    chk("torque clamp", rv, 16'h012C);
    t = 16'($urandom_range(300));
    reg_wr(OLSC_ADDR_PLUG_TORQUE, t);
    tick(3);
    chk("torque limit", drv.torque_limit, t);
    reg_wr(OLSC_ADDR_RATED_CAP, t >> 1);
    tick(3);
    chk("rated cap", drv.torque_limit, t >> 1);
    reg_wr(OLSC_ADDR_RATED_CAP, 16'h012C);
    reg_wr(OLSC_ADDR_STOP_CFG, 16'h0005);
    reg_rd(OLSC_ADDR_ACTIVE_CFG, rv);
    chk("active early", rv, 16'h0000);
    cycle_power;
    reg_rd(OLSC_ADDR_ACTIVE_CFG, rv);
    chk("active late", rv, 16'h0005);
    for (int i = 0; i < 12; i++) begin
      q = 4'(i);
      en = {7'h00, q[1], 3'h0, q[0], 4'h0};
      reg_wr(OLSC_ADDR_ENABLE_CFG, en);
      cycle_power;
      u_ptn.set_lim(q[3:2] != 2'h2, q[3:2] != 2'h1);
      tick(5);
      ff = fl & ~q[0];
      rf = rl & ~q[1];
      chk("fwd flag", 16'(fot), 16'(ff));
      chk("rev flag", 16'(rot), 16'(rf));
      chk("permits", 16'({drv.fwd_permit, drv.rev_permit}), 16'({~ff, ~rf}));
      reg_rd(OLSC_ADDR_STATUS, rv);
      chk("status", rv, {14'h0000, rf, ff});
      u_ptn.set_lim(1'b0, 1'b0);
      tick(5);
    end
    reg_wr(OLSC_ADDR_ENABLE_CFG, 16'h0000);
    // reverse rotation mode: the forward pin now guards the reverse side
    reg_wr(OLSC_ADDR_ROT_DIR_CFG, 16'h0001);
    cycle_power;
    u_ptn.set_lim(1'b1, 1'b0);
    tick(5);
    chk("swapped flags", 16'({rot, fot}), 16'h0002);
    chk("swapped permit", 16'({drv.fwd_permit, drv.rev_permit}), 16'h0002);
    u_ptn.set_lim(1'b0, 1'b0);
    reg_wr(OLSC_ADDR_ROT_DIR_CFG, 16'h0000);
    tick(5);
    for (int i = 0; i < 6; i++) begin
      c = 4'(i);
      reg_wr(OLSC_ADDR_STOP_CFG, {12'h000, c});
      cycle_power;
      u_ptn.set_host(1'b1, 1'b1, 1'b0, 1'b0);
      u_ptn.set_lim(1'b1, 1'b0);
      tick(6);
      chk("braking", modes(), exp_mode(0, c));
      u_ptn.set_host(1'b1, 1'b1, 1'b0, 1'b1);
      tick(3);
      chk("stopped", modes(), exp_mode(1, c));
      u_ptn.set_host(1'b0, 1'b1, 1'b0, 1'b1);
      tick(3);
      chk("servo off", modes(), exp_mode(2, c));
      u_ptn.set_lim(1'b0, 1'b0);
      u_ptn.set_host(1'b1, 1'b0, 1'b0, 1'b0);
      tick(6);
    end
    u_ptn.set_lim(1'b1, 1'b0);
    u_ptn.set_host(1'b1, 1'b0, 1'b1, 1'b0);
    exp_err = 16'h0000;
    repeat ($urandom_range(20, 1)) begin
      d = (exp_err == 16'h0000) ? 1'b0 : 1'($urandom_range(1));
      u_ptn.count(d);
      exp_err = d ? exp_err - 16'h0001 : exp_err + 16'h0001;
    end
    tick(6);
    chk("back off", 16'(drv.rev_permit), 16'h0001);
    chk("error kept", perr, exp_err);
    u_ptn.clear;
    tick(2);
    chk("error cleared", perr, 16'h0000);
    print_verdict;
  end
endmodule : tb_overtravel_limit_stop_control
